/* src/bmsp_pkg.sv */
/*
  Shared constants and types for the battery monitor serial host port.
  Assumes a 250 MHz system clock driving the host controller.
*/
package bmsp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS        = 4;       // system clock period
  localparam int unsigned SCLK_HALF_NS  = 250;     // half bit at 2 Mbps
  localparam int unsigned HALF_CYC      = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CS_TIMEOUT_NS = 100000;  // chip select high timeout
  localparam int unsigned TIMEOUT_CYC   = CS_TIMEOUT_NS / CLK_NS;

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_BITS  = 8;
  localparam logic [1:0]  WR_LAST    = 2'h2;   // three bytes, index of last
  localparam logic [1:0]  RD_LAST    = 2'h3;   // two command + two response
  localparam logic [1:0]  CHAIN_LAST = 2'h0;   // one byte per handshake
  localparam int unsigned RSP_BITS   = 14;
  localparam logic        FLAG_WRITE = 1'b1;
  localparam logic        FLAG_READ  = 1'b0;
  localparam logic [2:0]  MEAS_PAGE  = 3'h3;
  localparam logic [5:0]  MEAS_LOC   = 6'h08;
  localparam logic [5:0]  FILL_BITS  = 6'h00;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_SETUP,
    ST_HIGH,
    ST_LOW,
    ST_GAP
  } bmsp_state_t;

endpackage

/* src/bmsp_sync2.sv */
/*
  Two-flop synchroniser for pin inputs.
  Assumes inputs are asynchronous to clock; first stage is read only by the second.
*/
`timescale 1ns/100ps
module bmsp_sync2 #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  input  wire logic [WIDTH-1:0] init,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } bmsp_sync_t;

  bmsp_sync_t sync_reg;
  bmsp_sync_t sync_next;
  logic       boot_reg;

  // ----------------------------------------------------------------
  // two stages
  // ----------------------------------------------------------------
  // second stage output takes the idle level for the first cycle after release
  always_comb
  begin
    sync_next.s1 = d;
    sync_next.s2 = boot_reg ? init : sync_reg.s1;
  end

  // reset loads constants only; init is caught after release
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_reg <= '0;
      boot_reg <= 1'b1;
    end
    else
    begin
      sync_reg <= sync_next;
      boot_reg <= 1'b0;
    end
  end

  assign q = sync_reg.s2;

endmodule // bmsp_sync2

/* src/bmsp_host.sv */
/*
  Host-side serial controller for a multi-cell battery monitor port.
  Generates the serial clock by division, frames each byte with chip
  select, builds stand-alone commands and services the chained-mode
  response-ready handshake. Assumes chain_mode and the command port
  are on clock; miso and ready_n come from pins.
*/
// Function
// - whole bytes, most significant bit first
// - chained clock at least twice link rate
// - select returns high between every byte
// - length set by first bit, well formed
// - third write byte returned is discarded
// - on ready: select low, eight bits, release
// - no command while ready low; cmd_ready lags ready one cycle, so one can be taken as it falls
// - never select ahead of ready
// - read two bytes, write three, reply two
// - write: flag, page, location, 14 data
// - read: fields, fill, keep low bits
`timescale 1ns/100ps
module bmsp_host
  import bmsp_pkg::*;
#(
  parameter int unsigned HALF     = HALF_CYC,
  parameter int unsigned BOOT_CYC = TIMEOUT_CYC + 1
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          chain_mode,
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire logic          cmd_write,
  input  wire logic [2:0]    cmd_page,
  input  wire logic [5:0]    cmd_loc,
  input  wire logic [13:0]   cmd_data,
  output logic               rsp_valid,
  output logic [RSP_BITS-1:0] rsp_data,
  output logic               rsp_chain,
  output logic               sclk,
  output logic               cs_n,
  output logic               mosi,
  input  wire logic          miso,
  input  wire logic          ready_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    bmsp_state_t           st;
    logic [15:0]           cnt;
    logic [2:0]            bitn;
    logic [1:0]            byten;
    logic [1:0]            last;
    logic [31:0]           txf;
    logic [15:0]           rxf;
    logic                  is_read;
    logic                  is_write;
    logic                  chain_rd;
    logic                  sclk;
    logic                  cs_n;
    logic                  mosi;
    logic                  cmd_ready;
    logic                  rsp_valid;
    logic [RSP_BITS-1:0]   rsp_data;
    logic                  rsp_chain;
  } bmsp_host_t;

  localparam logic [15:0] HALF_END = 16'(HALF - 1);
  localparam logic [15:0] BOOT_END = 16'(BOOT_CYC - 1);

  bmsp_host_t r_reg;
  bmsp_host_t r_next;
  logic [1:0] pins_s;
  logic       miso_s;
  logic       rdy_s;
  logic       take_cmd;

  // pins cross into clock through two flops; ready idles high
  bmsp_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({miso, ready_n}),
    .init  (2'b01),
    .q     (pins_s)
  );
  assign miso_s = pins_s[1];
  assign rdy_s  = pins_s[0];

  // measure command carries the element in the last six bits
  function automatic logic is_measure(input logic [2:0] pg, input logic [5:0] lc);
    is_measure = (pg == MEAS_PAGE) && (lc == MEAS_LOC);
  endfunction

  assign take_cmd = cmd_valid && r_reg.cmd_ready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one byte: select low, half, eight high/low bit cells, select high, half
  always_comb
  begin
    r_next           = r_reg;
    r_next.rsp_valid = 1'b0;
    unique case (r_reg.st)
      ST_BOOT:
      begin
        // hold select high past the timeout so the port starts clean
        if (r_reg.cnt == BOOT_END)
        begin
          r_next.st  = ST_IDLE;
          r_next.cnt = '0;
        end
        else
          r_next.cnt = r_reg.cnt + 16'h0001;
      end
      ST_IDLE:
      begin
        r_next.cnt       = '0;
        r_next.bitn      = '0;
        r_next.byten     = '0;
        // commands are held off from the cycle after ready is seen low; a command taken as ready falls wins over the reply
        r_next.cmd_ready = !(chain_mode && !rdy_s);
        if (take_cmd)
        begin
          r_next.cmd_ready = 1'b0;
          r_next.st        = ST_SETUP;
          r_next.cs_n      = 1'b0;
          r_next.chain_rd  = 1'b0;
          if (chain_mode)
          begin
            r_next.txf      = {cmd_data[7:0], 24'h000000};
            r_next.last     = CHAIN_LAST;
            r_next.is_read  = 1'b0;
            r_next.is_write = 1'b0;
          end
          else if (cmd_write)
          begin
            // flag, page, location, 14 data bits, three bytes
            r_next.txf      = {FLAG_WRITE, cmd_page, cmd_loc, cmd_data, 8'h00};
            r_next.last     = WR_LAST;
            r_next.is_read  = 1'b0;
            r_next.is_write = 1'b1;
          end
          else
          begin
            // two command bytes, then two bytes to clock the reply out
            r_next.txf      = {FLAG_READ, cmd_page, cmd_loc,
                               is_measure(cmd_page, cmd_loc) ? cmd_data[5:0] : FILL_BITS,
                               16'h0000};
            r_next.last     = RD_LAST;
            r_next.is_read  = 1'b1;
            r_next.is_write = 1'b0;
          end
          r_next.mosi = r_next.txf[31];
        end
        else if (chain_mode && !rdy_s)
        begin
          // select only after ready is seen low
          r_next.cmd_ready = 1'b0;
          r_next.st        = ST_SETUP;
          r_next.cs_n      = 1'b0;
          r_next.chain_rd  = 1'b1;
          r_next.is_read   = 1'b0;
          r_next.is_write  = 1'b0;
          r_next.txf       = '0;
          r_next.last      = CHAIN_LAST;
          r_next.mosi      = 1'b0;
        end
      end
      ST_SETUP:
      begin
        if (r_reg.cnt == HALF_END)
        begin
          r_next.cnt  = '0;
          r_next.sclk = 1'b1;
          r_next.st   = ST_HIGH;
        end
        else
          r_next.cnt = r_reg.cnt + 16'h0001;
      end
      ST_HIGH:
      begin
        // sample late in the high phase; data changed on the fall
        if (r_reg.cnt == HALF_END)
        begin
          r_next.cnt  = '0;
          r_next.rxf  = {r_reg.rxf[14:0], miso_s};
          r_next.sclk = 1'b0;
          r_next.txf  = {r_reg.txf[30:0], 1'b0};
          r_next.mosi = r_reg.txf[30];
          r_next.bitn = r_reg.bitn + 3'h1;
          r_next.st   = ST_LOW;
        end
        else
          r_next.cnt = r_reg.cnt + 16'h0001;
      end
      ST_LOW:
      begin
        if (r_reg.cnt == HALF_END)
        begin
          r_next.cnt = '0;
          if (r_reg.bitn == 3'h0)
          begin
            r_next.cs_n = 1'b1;
            r_next.st   = ST_GAP;
          end
          else
          begin
            r_next.sclk = 1'b1;
            r_next.st   = ST_HIGH;
          end
        end
        else
          r_next.cnt = r_reg.cnt + 16'h0001;
      end
      ST_GAP:
      begin
        // gap is far below the timeout, so bytes of one command stay joined
        if (r_reg.cnt == HALF_END)
        begin
          r_next.cnt = '0;
          if (r_reg.byten == r_reg.last)
          begin
            r_next.st = ST_IDLE;
            // write replies are dropped; only reads report
            if (r_reg.is_read || r_reg.chain_rd)
            begin
              r_next.rsp_valid = 1'b1;
              r_next.rsp_chain = r_reg.chain_rd;
              r_next.rsp_data  = r_reg.chain_rd ? {6'h00, r_reg.rxf[7:0]}
                                                : r_reg.rxf[RSP_BITS-1:0];
            end
          end
          else
          begin
            r_next.byten = r_reg.byten + 2'h1;
            r_next.cs_n  = 1'b0;
            r_next.st    = ST_SETUP;
          end
        end
        else
          r_next.cnt = r_reg.cnt + 16'h0001;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // select idles high and clock idles low from reset on
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg      <= '0;
      r_reg.st   <= ST_BOOT;
      r_reg.cs_n <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  assign cmd_ready = r_reg.cmd_ready;
  assign rsp_valid = r_reg.rsp_valid;
  assign rsp_data  = r_reg.rsp_data;
  assign rsp_chain = r_reg.rsp_chain;
  assign sclk      = r_reg.sclk;
  assign cs_n      = r_reg.cs_n;
  assign mosi      = r_reg.mosi;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // rising edges seen inside one select-low window
  logic [3:0]  rise_cnt;
  logic        sclk_d;
  logic [15:0] hi_cnt;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_cnt <= '0;
      sclk_d   <= 1'b0;
      hi_cnt   <= '0;
    end
    else
    begin
      sclk_d <= r_reg.sclk;
      if (!r_reg.cs_n)
        hi_cnt <= '0;
      else if (hi_cnt != 16'hFFFF)
        hi_cnt <= hi_cnt + 16'h0001;
      if (r_reg.cs_n)
        rise_cnt <= '0;
      else if (r_reg.sclk && !sclk_d)
        rise_cnt <= rise_cnt + 4'h1;
    end
  end

  a_eight_bits: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(r_reg.cs_n) |-> rise_cnt == 4'h8)
    else $error("select released without exactly eight clocks");

  a_select_gap: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(r_reg.cs_n) |-> hi_cnt > HALF_END)
    else $error("select high gap too short");

  a_clock_rate: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(r_reg.sclk) |-> $past(r_reg.cnt) == HALF_END)
    else $error("serial clock high phase not a full half period");

  a_clock_idle: assert property (@(posedge clock) disable iff (!rst_n)
    r_reg.cs_n |-> !r_reg.sclk)
    else $error("serial clock active while deselected");

  a_ready_first: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(r_reg.chain_rd) |-> !$past(rdy_s) && $fell(r_reg.cs_n))
    else $error("chained read selected without ready");

  a_cmd_held: assert property (@(posedge clock) disable iff (!rst_n)
    take_cmd && chain_mode |-> $past(rdy_s))
    else $error("command accepted while reply pending");

  a_write_frame: assert property (@(posedge clock) disable iff (!rst_n)
    take_cmd && !chain_mode && cmd_write |=> r_reg.last == WR_LAST && r_reg.mosi)
    else $error("write frame malformed");

  a_read_frame: assert property (@(posedge clock) disable iff (!rst_n)
    take_cmd && !chain_mode && !cmd_write |=> r_reg.last == RD_LAST && !r_reg.mosi)
    else $error("read frame malformed");

  a_write_silent: assert property (@(posedge clock) disable iff (!rst_n)
    r_reg.rsp_valid |-> !r_reg.is_write)
    else $error("reply reported for a write");

  a_boot_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    r_reg.st == ST_BOOT |-> r_reg.cs_n && !r_reg.cmd_ready)
    else $error("port active before timeout wait");

  c_write_done: cover property (@(posedge clock) disable iff (!rst_n)
    r_reg.is_write && r_reg.st == ST_GAP ##1 r_reg.st == ST_IDLE);
  c_read_done: cover property (@(posedge clock) disable iff (!rst_n)
    r_reg.rsp_valid && !r_reg.rsp_chain);
  c_chain_read: cover property (@(posedge clock) disable iff (!rst_n)
    r_reg.rsp_valid && r_reg.rsp_chain);

endmodule // bmsp_host

/* tb/bmsp_dev_model.sv */
/*
  Behavioural device at the far end of the monitor serial port.
  Assumes mode 0 framing and one byte per select-low period.
*/
`timescale 1ns/100ps
module bmsp_dev_model (
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  input  wire logic chain,
  output logic      miso,
  output logic      ready_n
);
  logic [13:0] mem [0:511];
  logic [31:0] frame = '0;
  logic [7:0]  tx;
  logic [13:0] obuf;
  logic [7:0]  q [$];
  int          bitn = 0;
  int          byten = 0;
  int          len = 4;
  int          gap_ns = 300;
  realtime     t_hi;

  initial
  begin
    miso = 1'h0;
    ready_n = 1'h1;
  end

  // --------------------------------------------------------------
  // shifting
  // --------------------------------------------------------------
  // input ignored while a chained reply waits; bits still counted so
  // the reply byte can be released when select rises
  always @(posedge sclk)
    if (!cs_n)
    begin
      bitn++;
      if (!(chain && !ready_n))
      begin
        frame = {frame[30:0], mosi};
        if (bitn == 1 && byten == 0) len = mosi ? 3 : 4;
      end
    end

  // reply loaded at select fall, first bit shows at once
  always @(negedge cs_n)
  begin
    if (byten == 0 || chain) frame = '0;
    if (chain) tx = (q.size() > 0) ? q[0] : 8'h00;
    else tx = (byten == 2) ? {2'h0, obuf[13:8]} : (byten == 3) ? obuf[7:0] : 8'h00;
    miso = tx[7];
  end

  always @(negedge sclk)
    if (!cs_n)
    begin
      tx = {tx[6:0], 1'h0};
      miso = tx[7];
    end

  // --------------------------------------------------------------
  // byte end: decode, store, release
  // --------------------------------------------------------------
  always @(posedge cs_n)
  begin
    t_hi = $realtime;
    miso = ~miso; // floating line must not keep last bit
    if (chain)
    begin
      if (!ready_n && bitn == 8) void'(q.pop_front());
      ready_n = 1'h1;
    end
    else if (bitn != 8) byten = 0;
    else
    begin
      byten++;
      if (byten == 2 && len == 4)
        obuf = (frame[14:6] == 9'h0C8) ? {8'h00, frame[5:0]} :
               (frame[14:12] inside {[1:5]}) ? mem[frame[14:6]] : 14'h0000;
      if (byten == 3 && len == 3 && frame[22:20] inside {[1:5]})
        mem[frame[22:14]] = frame[13:0]; // no reply to writes
      if (byten == len) byten = 0;
    end
    bitn = 0;
  end

  // long select-high period clears the byte count
  always @(posedge cs_n)
  begin
    #100000;
    if (cs_n && $realtime - t_hi >= 100000) byten = 0;
  end

  // ready only raised while select is high
  always
  begin
    #(gap_ns);
    if (chain && cs_n && ready_n && q.size() > 0) ready_n = 1'h0;
  end
endmodule // bmsp_dev_model

/* tb/tb_bmsp_host.sv */
/*
  Self-checking bench for the host serial controller.
  Assumes the device model in bmsp_dev_model.sv on the far side.
*/
`timescale 1ns/100ps
module tb_bmsp_host;
  import bmsp_pkg::*;
  localparam int unsigned HALF_T = 4;
  localparam int unsigned BOOT_T = 20;
  logic                clock = 1'h0;
  logic                rst_n = 1'h0;
  logic                chain_mode = 1'h0;
  logic                cmd_valid = 1'h0;
  logic                cmd_write = 1'h0;
  logic [2:0]          cmd_page = 3'h0;
  logic [5:0]          cmd_loc = 6'h00;
  logic [13:0]         cmd_data = 14'h0000;
  logic                cmd_ready, rsp_valid, rsp_chain, sclk, cs_n, mosi, miso, ready_n;
  logic [RSP_BITS-1:0] rsp_data;
  int                  n_errors = 0;
  int                  tests_run = 0;
  int                  cyc = 0;
  int                  nclk = 0;
  int                  nrsp = 0;

  always #2 clock = ~clock;

  bmsp_host #(.HALF(HALF_T), .BOOT_CYC(BOOT_T)) bmsp_host_i (
    .clock(clock), .rst_n(rst_n), .chain_mode(chain_mode), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_page(cmd_page), .cmd_loc(cmd_loc),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_chain(rsp_chain),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .ready_n(ready_n));

  bmsp_dev_model bmsp_dev_model_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .chain(chain_mode), .miso(miso), .ready_n(ready_n));

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard, runs well beyond the expected length
  always @(posedge clock)
  begin
    cyc++;
    if (rsp_valid === 1'h1) nrsp++;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict;
    end
  end

  // every select-low period carries exactly one byte
  always @(posedge sclk) nclk++;
  always @(posedge cs_n)
    if (rst_n === 1'h1)
    begin
      chk("clocks per select", 8, nclk);
      nclk = 0;
    end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic issue(input logic wr, input logic [2:0] pg, input logic [5:0] lc,
                       input logic [13:0] d);
    @(posedge clock);
    cmd_valid <= 1'h1;
    cmd_write <= wr;
    cmd_page <= pg;
    cmd_loc <= lc;
    cmd_data <= d;
    do @(posedge clock); while (cmd_ready !== 1'h1);
    cmd_valid <= 1'h0;
  endtask

  task automatic await_idle;
    do @(posedge clock); while (cmd_ready !== 1'h1);
  endtask

  task automatic await_rsp(input logic ch, input logic [13:0] d, input string what);
    do @(posedge clock); while (rsp_valid !== 1'h1);
    chk(what, {ch, d}, {rsp_chain, rsp_data});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_boot;
    int  n;
    logic hi;
    n = 0;
    hi = 1'h1;
    do
    begin
      @(posedge clock);
      n++;
      if (cs_n !== 1'h1) hi = 1'h0;
    end while (cmd_ready !== 1'h1 && n < 1000);
    chk("boot wait", 1, n >= BOOT_T && n < 1000 && hi);
  endtask

  task automatic t_write_read;
    int n0;
    n0 = nrsp;
    issue(1'h1, 3'h1, 6'h05, 14'h2A5C);
    await_idle;
    chk("write frame", {8'h00, 1'h1, 3'h1, 6'h05, 14'h2A5C}, {8'h00, bmsp_dev_model_i.frame[23:0]});
    chk("write reply", n0, nrsp);
    issue(1'h0, 3'h1, 6'h05, 14'h3FFF);
    await_rsp(1'h0, 14'h2A5C, "read back");
    await_idle;
    chk("read frame", {1'h0, 3'h1, 6'h05, 6'h00, 16'h0000}, bmsp_dev_model_i.frame);
  endtask

  task automatic t_measure;
    issue(1'h0, 3'h3, 6'h08, 14'h0005);
    await_rsp(1'h0, 14'h0005, "measure");
    await_idle;
    chk("measure frame", {1'h0, 3'h3, 6'h08, 6'h05, 16'h0000}, bmsp_dev_model_i.frame);
    issue(1'h0, 3'h6, 6'h01, 14'h0000);
    await_rsp(1'h0, 14'h0000, "unknown read");
  endtask

  task automatic t_chain;
    @(posedge clock);
    chain_mode <= 1'h1;
    bmsp_dev_model_i.q.push_back(8'hA5);
    bmsp_dev_model_i.q.push_back(8'h3C);
    await_rsp(1'h1, 14'h00A5, "chain byte one");
    bmsp_dev_model_i.gap_ns = 2000;
    await_rsp(1'h1, 14'h003C, "chain byte two");
    await_idle;
    issue(1'h0, 3'h0, 6'h00, 14'h0096);
    await_idle;
    chk("chain send", 8'h96, bmsp_dev_model_i.frame[7:0]);
    chain_mode <= 1'h0;
  endtask

  initial
  begin
    repeat (5) @(posedge clock);
    rst_n <= 1'h1;
    t_boot;
    t_write_read;
    t_measure;
    t_chain;
    print_verdict;
  end
endmodule // tb_bmsp_host
